// >>> icdbg_pkg.sv
// icdbg_pkg: constants, encodings and state layout of the icache debug-read block.
// assumes: the core numbers bits with bit 0 as msb; here vectors are lsb-0, so
// field positions below are already converted to [31:0] indexing.
package icdbg_pkg;

    // special register address of icache_debug_data
    localparam logic [9:0] ICDBG_SPR_DEBUG_DATA = 10'h3D3;

    // effective-address fields (lsb-0 indices of ea[31:0])
    localparam int ICDBG_EA_SET_LSB = 5;
    localparam int ICDBG_EA_SET_W = 5;
    localparam int ICDBG_EA_WORD_LSB = 2;
    localparam int ICDBG_EA_WORD_W = 3;

    // icache_debug_data layout (lsb-0 indices)
    localparam int ICDBG_LINE_CONTENT_FIELD_LSB = 10;
    localparam int ICDBG_LINE_CONTENT_FIELD_W = 22;
    localparam int ICDBG_VALID_BIT = 4;
    localparam int ICDBG_LRU_BIT = 0;
    localparam logic [31:0] ICDBG_DEBUG_RESET = 32'h0000_0000;

    // way_select and line_content_field_select encodings
    localparam logic ICDBG_WAY_A = 1'b0;
    localparam logic ICDBG_WAY_B = 1'b1;
    localparam logic ICDBG_LINE_CONTENT_FIELD_WORD = 1'b0;
    localparam logic ICDBG_LINE_CONTENT_FIELD_TAG = 1'b1;

    typedef enum logic [2:0] {
        ICDBG_OP_NONE = 3'h0,
        ICDBG_OP_ICREAD = 3'h1,
        ICDBG_OP_CTXSYNC = 3'h2,
        ICDBG_OP_STOREBACK = 3'h3,
        ICDBG_OP_MEMSYNC = 3'h4,
        ICDBG_OP_ICINVAL = 3'h5,
        ICDBG_OP_DCFLUSH = 3'h6
    } icdbg_op_t;

    // gray-coded along idle -> read -> dcache wait -> memory sync wait
    typedef enum logic [1:0] {
        ICDBG_ST_IDLE = 2'h0,
        ICDBG_ST_ARRAY = 2'h1,
        ICDBG_ST_DCWAIT = 2'h3,
        ICDBG_ST_SYNCWAIT = 2'h2
    } icdbg_state_t;

    typedef struct packed {
        icdbg_op_t op;
        logic [31:0] ea;
    } icdbg_cmd_t;

    typedef struct packed {
        logic [21:0] tag;
        logic valid;
        logic lru;
        logic [31:0] word;
    } icdbg_array_t;

    typedef struct packed {
        icdbg_state_t state;
        logic busy;
        logic [31:0] debug_data;
        logic line_content_field_sel;
        logic arr_rd;
        logic [4:0] arr_set;
        logic arr_way;
        logic [2:0] arr_word;
        logic ic_inval;
        logic [31:0] maint_ea;
        logic dc_req;
        logic dc_flush;
        logic pf_discard;
        logic spr_ack;
        logic [31:0] spr_rdata;
        logic priv_fault;
    } icdbg_regs_t;

endpackage : icdbg_pkg

// >>> icdbg_top.sv
// icdbg_top: icache debug read into icache_debug_data plus cache-control sequencing.
// assumes: one command at a time from the pipeline (cmd_ready_o handshake); the icache
// array answers combinationally while arr_rd_o is high; the dcache and memory side
// answer dc_done_i / mem_pending_i.
`timescale 1ns/10ps
module icdbg_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // command from the pipeline
    input wire logic cmd_valid_i,
    input wire icdbg_pkg::icdbg_cmd_t cmd_i,
    output logic cmd_ready_o,
    // core_config_reg fields
    input wire logic way_select_i,
    input wire logic line_content_field_select_i,
    // icache array read port and invalidate
    output logic arr_rd_o,
    output logic [4:0] arr_set_o,
    output logic arr_way_o,
    output logic [2:0] arr_word_o,
    input wire icdbg_pkg::icdbg_array_t arr_i,
    output logic ic_inval_o,
    // dcache maintenance, memory sync and prefetch discard
    output logic dc_req_o,
    output logic dc_flush_o,
    output logic [31:0] maint_ea_o,
    input wire logic dc_done_i,
    input wire logic mem_pending_i,
    output logic prefetch_discard_o,
    // special register read
    input wire logic spr_rd_i,
    input wire logic [9:0] spr_addr_i,
    input wire logic priv_i,
    output logic spr_ack_o,
    output logic [31:0] spr_rdata_o,
    output logic priv_fault_o
);

    icdbg_pkg::icdbg_regs_t r_ff;
    icdbg_pkg::icdbg_regs_t nxt_r;
    logic take;
    logic [31:0] word_pick;
    logic [31:0] captured;

    assign take = cmd_valid_i && !r_ff.busy;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.ic_inval = 1'b0;
        nxt_r.pf_discard = 1'b0;
        nxt_r.arr_rd = 1'b0;
        nxt_r.spr_ack = 1'b0;
        nxt_r.priv_fault = 1'b0;
        word_pick = arr_i.word;
        captured = 32'h0000_0000; // reserved bits stay zero
        captured[icdbg_pkg::ICDBG_LINE_CONTENT_FIELD_LSB +: icdbg_pkg::ICDBG_LINE_CONTENT_FIELD_W] =
            (r_ff.line_content_field_sel == icdbg_pkg::ICDBG_LINE_CONTENT_FIELD_TAG) ? arr_i.tag
            : word_pick[31 -: icdbg_pkg::ICDBG_LINE_CONTENT_FIELD_W];
        captured[icdbg_pkg::ICDBG_VALID_BIT] = arr_i.valid;
        captured[icdbg_pkg::ICDBG_LRU_BIT] = arr_i.lru;
        case (r_ff.state)
            icdbg_pkg::ICDBG_ST_IDLE: begin
                if (take) begin
                    nxt_r.maint_ea = cmd_i.ea;
                    case (cmd_i.op)
                        icdbg_pkg::ICDBG_OP_ICREAD: begin
                            nxt_r.state = icdbg_pkg::ICDBG_ST_ARRAY;
                            nxt_r.busy = 1'b1;
                            nxt_r.arr_rd = 1'b1;
                            nxt_r.arr_set = cmd_i.ea[icdbg_pkg::ICDBG_EA_SET_LSB +:
                                icdbg_pkg::ICDBG_EA_SET_W];
                            nxt_r.arr_way = way_select_i;
                            nxt_r.arr_word = cmd_i.ea[icdbg_pkg::ICDBG_EA_WORD_LSB +:
                                icdbg_pkg::ICDBG_EA_WORD_W];
                            nxt_r.line_content_field_sel = line_content_field_select_i;
                        end
                        icdbg_pkg::ICDBG_OP_CTXSYNC: begin
                            nxt_r.pf_discard = 1'b1;
                        end
                        icdbg_pkg::ICDBG_OP_ICINVAL: begin
                            nxt_r.ic_inval = 1'b1;
                        end
                        icdbg_pkg::ICDBG_OP_STOREBACK, icdbg_pkg::ICDBG_OP_DCFLUSH: begin
                            nxt_r.state = icdbg_pkg::ICDBG_ST_DCWAIT;
                            nxt_r.busy = 1'b1;
                            nxt_r.dc_req = 1'b1;
                            nxt_r.dc_flush = (cmd_i.op == icdbg_pkg::ICDBG_OP_DCFLUSH);
                        end
                        icdbg_pkg::ICDBG_OP_MEMSYNC: begin
                            if (mem_pending_i) begin
                                nxt_r.state = icdbg_pkg::ICDBG_ST_SYNCWAIT;
                                nxt_r.busy = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            icdbg_pkg::ICDBG_ST_ARRAY: begin
                nxt_r.debug_data = captured;
                nxt_r.state = icdbg_pkg::ICDBG_ST_IDLE;
                nxt_r.busy = 1'b0;
            end
            icdbg_pkg::ICDBG_ST_DCWAIT: begin
                if (dc_done_i) begin
                    nxt_r.dc_req = 1'b0;
                    nxt_r.dc_flush = 1'b0;
                    nxt_r.state = icdbg_pkg::ICDBG_ST_IDLE;
                    nxt_r.busy = 1'b0;
                end
            end
            icdbg_pkg::ICDBG_ST_SYNCWAIT: begin
                if (!mem_pending_i) begin
                    nxt_r.state = icdbg_pkg::ICDBG_ST_IDLE;
                    nxt_r.busy = 1'b0;
                end
            end
            default: begin
                nxt_r.state = icdbg_pkg::ICDBG_ST_IDLE;
                nxt_r.busy = 1'b0;
            end
        endcase
        // a read racing an unsynchronised debug read sees the older value
        if (spr_rd_i && spr_addr_i == icdbg_pkg::ICDBG_SPR_DEBUG_DATA) begin
            nxt_r.spr_ack = 1'b1;
            nxt_r.priv_fault = !priv_i;
            nxt_r.spr_rdata = priv_i ? r_ff.debug_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            r_ff <= '0;
            r_ff.debug_data <= icdbg_pkg::ICDBG_DEBUG_RESET;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign cmd_ready_o = !r_ff.busy;
    assign arr_rd_o = r_ff.arr_rd;
    assign arr_set_o = r_ff.arr_set;
    assign arr_way_o = r_ff.arr_way;
    assign arr_word_o = r_ff.arr_word;
    assign ic_inval_o = r_ff.ic_inval;
    assign dc_req_o = r_ff.dc_req;
    assign dc_flush_o = r_ff.dc_flush;
    assign maint_ea_o = r_ff.maint_ea;
    assign prefetch_discard_o = r_ff.pf_discard;
    assign spr_ack_o = r_ff.spr_ack;
    assign spr_rdata_o = r_ff.spr_rdata;
    assign priv_fault_o = r_ff.priv_fault;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_icread_taken;
        take && cmd_i.op == icdbg_pkg::ICDBG_OP_ICREAD;
    endsequence

    sequence s_array_cycle;
        arr_rd_o ##1 !arr_rd_o;
    endsequence

    a_set_from_ea: assert property (s_icread_taken |=> arr_set_o == $past(cmd_i.ea[9:5]))
        else $error("set index not taken from ea");
    a_way_from_cfg: assert property (s_icread_taken |=> arr_way_o == $past(way_select_i))
        else $error("way not taken from way_select");
    a_word_from_ea: assert property (s_icread_taken |=> arr_word_o == $past(cmd_i.ea[4:2]))
        else $error("word index not taken from ea");
    a_capture_path: assert property (s_icread_taken |=> s_array_cycle)
        else $error("array read not one cycle");
    a_line_content_field_tag: assert property (arr_rd_o && r_ff.line_content_field_sel |=>
        r_ff.debug_data[31:10] == $past(arr_i.tag))
        else $error("tag not captured");
    a_line_content_field_word: assert property (arr_rd_o && !r_ff.line_content_field_sel |=>
        r_ff.debug_data[31:10] == $past(arr_i.word[31:10]))
        else $error("instruction word not captured");
    a_valid_lru: assert property (arr_rd_o |=> r_ff.debug_data[4] == $past(arr_i.valid)
        && r_ff.debug_data[0] == $past(arr_i.lru))
        else $error("valid or lru not captured");
    a_reserved_zero: assert property (r_ff.debug_data[9:5] == 5'h00
        && r_ff.debug_data[3:1] == 3'h0)
        else $error("reserved bits not zero");
    a_spr_privilege: assert property (spr_rd_i && spr_addr_i == 10'h3D3 && !priv_i
        |=> priv_fault_o && spr_ack_o && spr_rdata_o == 32'h0000_0000)
        else $error("unprivileged read not refused");
    a_ctxsync_discard: assert property (take && cmd_i.op == icdbg_pkg::ICDBG_OP_CTXSYNC
        |=> prefetch_discard_o ##1 !prefetch_discard_o)
        else $error("prefetch discard missing");
    a_sync_stall: assert property (r_ff.state == icdbg_pkg::ICDBG_ST_SYNCWAIT
        && mem_pending_i |=> !cmd_ready_o)
        else $error("sync did not stall");
    a_sync_enter: assert property (take && cmd_i.op == icdbg_pkg::ICDBG_OP_MEMSYNC
        && mem_pending_i |=> !cmd_ready_o)
        else $error("sync with pending updates did not stall");
    a_dc_hold: assert property (dc_req_o && !dc_done_i |=> dc_req_o
        && $stable(dc_flush_o))
        else $error("dcache request dropped early");
    a_inval_pulse: assert property (take && cmd_i.op == icdbg_pkg::ICDBG_OP_ICINVAL
        |=> ic_inval_o && maint_ea_o == $past(cmd_i.ea))
        else $error("invalidate not issued");
    a_flush_kind: assert property (take && cmd_i.op == icdbg_pkg::ICDBG_OP_DCFLUSH
        |=> dc_req_o && dc_flush_o)
        else $error("flush not issued");

endmodule : icdbg_top

// >>> icdbg_cache_model.sv
// icdbg_cache_model: icache array and dcache stand-in facing icdbg_top.
// assumes: line contents are a pure function of set, way and word.
`timescale 1ns/10ps
module icdbg_cache_model (
    // clock
    input wire logic clock_i,
    // array read port
    input wire logic arr_rd_i,
    input wire logic [4:0] arr_set_i,
    input wire logic arr_way_i,
    input wire logic [2:0] arr_word_i,
    output icdbg_pkg::icdbg_array_t arr_o,
    // dcache maintenance, done after dc_delay_i cycles
    input wire logic dc_req_i,
    input wire logic [3:0] dc_delay_i,
    output logic dc_done_o
);
    icdbg_pkg::icdbg_array_t line;
    logic [3:0] wait_ff;
    assign line = '{tag: {arr_set_i, arr_way_i, 16'hA5C3}, valid: arr_set_i[0] ^ arr_way_i,
                    lru: arr_set_i[2], word: {arr_set_i, arr_way_i, arr_word_i, 23'h12345}};
    // outside a read the port shows the inverse, never a stale copy
    assign arr_o = arr_rd_i ? line : icdbg_pkg::icdbg_array_t'(~line);
    assign dc_done_o = dc_req_i && (wait_ff == dc_delay_i);
    always @(posedge clock_i) begin
        wait_ff <= (dc_req_i && !dc_done_o) ? wait_ff + 4'h1 : 4'h0;
    end
endmodule : icdbg_cache_model

// >>> testbench.sv
// testbench: commands and special register reads into icdbg_top, checked results.
// assumes: icdbg_cache_model answers the array and dcache side.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    $display("ERROR %s expected %h seen %h", nm, ex, gt); n_errors++; end end
module testbench;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    icdbg_pkg::icdbg_cmd_t cmd_i = '0;
    logic way_select_i = 1'b0;
    logic line_content_field_select_i = 1'b0;
    logic mem_pending_i = 1'b0;
    logic spr_rd_i = 1'b0;
    logic [9:0] spr_addr_i = 10'h000;
    logic priv_i = 1'b1;
    logic [3:0] dc_delay = 4'h0;
    logic cmd_ready_o, arr_rd_o, arr_way_o, ic_inval_o, dc_req_o, dc_flush_o, dc_done_i;
    logic prefetch_discard_o, spr_ack_o, priv_fault_o;
    logic [4:0] arr_set_o;
    logic [2:0] arr_word_o;
    logic [31:0] maint_ea_o, spr_rdata_o;
    icdbg_pkg::icdbg_array_t arr_i;
    int n_errors = 0, n_checks = 0, n_rd = 0, n_pf = 0;
    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        n_rd <= n_rd + int'(arr_rd_o === 1'b1);
        n_pf <= n_pf + int'(prefetch_discard_o === 1'b1);
    end
    icdbg_top i_icdbg_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .way_select_i(way_select_i),
        .line_content_field_select_i(line_content_field_select_i), .arr_rd_o(arr_rd_o), .arr_set_o(arr_set_o),
        .arr_way_o(arr_way_o), .arr_word_o(arr_word_o), .arr_i(arr_i), .ic_inval_o(ic_inval_o),
        .dc_req_o(dc_req_o), .dc_flush_o(dc_flush_o), .maint_ea_o(maint_ea_o),
        .dc_done_i(dc_done_i), .mem_pending_i(mem_pending_i),
        .prefetch_discard_o(prefetch_discard_o), .spr_rd_i(spr_rd_i), .spr_addr_i(spr_addr_i),
        .priv_i(priv_i), .spr_ack_o(spr_ack_o), .spr_rdata_o(spr_rdata_o),
        .priv_fault_o(priv_fault_o));
    icdbg_cache_model i_icdbg_cache_model (.clock_i(clock_i), .arr_rd_i(arr_rd_o),
        .arr_set_i(arr_set_o), .arr_way_i(arr_way_o), .arr_word_i(arr_word_o), .arr_o(arr_i),
        .dc_req_i(dc_req_o), .dc_delay_i(dc_delay), .dc_done_o(dc_done_i));
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 40) begin
            @(negedge clock_i);
            n++;
        end
        `CHK("cmd_ready_o", 1'b1, cmd_ready_o)
    endtask : wait_ready
    // returns in the cycle right after the take edge
    task automatic issue(input icdbg_pkg::icdbg_op_t op, input logic [31:0] ea);
        wait_ready();
        cmd_valid_i = 1'b1;
        cmd_i = '{op: op, ea: ea};
        @(negedge clock_i);
        cmd_valid_i = 1'b0;
    endtask : issue
    task automatic spr_read(input logic [9:0] a, input logic p, input logic ack,
                            input logic flt, input logic [31:0] d);
        spr_rd_i = 1'b1;
        spr_addr_i = a;
        priv_i = p;
        @(negedge clock_i);
        spr_rd_i = 1'b0;
        `CHK("spr_ack_o", ack, spr_ack_o)
        `CHK("priv_fault_o", flt, priv_fault_o)
        if (ack) `CHK("spr_rdata_o", d, spr_rdata_o)
        @(negedge clock_i);
        `CHK("spr_ack_o end", 1'b0, spr_ack_o)
    endtask : spr_read
    function automatic logic [31:0] exp_dbg(input logic [31:0] ea, input logic w, input logic f);
        logic [31:0] wv;
        wv = {ea[9:5], w, ea[4:2], 23'h12345};
        return {f ? {ea[9:5], w, 16'hA5C3} : wv[31:10], 5'h00, ea[5] ^ w, 3'h0, ea[7]};
    endfunction : exp_dbg
    initial begin
        #(25 * 2000);
        n_errors++;
        give_verdict();
    end
    initial begin
        logic [31:0] eas [3];
        int p0, r0;
        eas = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h1234_5154};
        repeat (3) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        spr_read(10'h3D3, 1'b1, 1'b1, 1'b0, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            way_select_i = i[0];
            line_content_field_select_i = i[1];
            {p0, r0} = {n_pf, n_rd};
            issue(icdbg_pkg::ICDBG_OP_ICREAD, eas[i / 4]);
            `CHK("arr_set_o", eas[i / 4][9:5], arr_set_o)
            `CHK("arr_way_o", i[0], arr_way_o)
            `CHK("arr_word_o", eas[i / 4][4:2], arr_word_o)
            way_select_i = ~i[0];
            line_content_field_select_i = ~i[1];
            issue(icdbg_pkg::ICDBG_OP_CTXSYNC, 32'h0000_0000);
            spr_read(10'h3D3, 1'b1, 1'b1, 1'b0, exp_dbg(eas[i / 4], i[0], i[1]));
            `CHK("prefetch_discard_o", p0 + 1, n_pf)
            `CHK("arr_rd_o", r0 + 1, n_rd)
        end
        spr_read(10'h3D2, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
        spr_read(10'h3D3, 1'b0, 1'b1, 1'b1, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            dc_delay = k ? 4'h2 : 4'h5;
            issue(k ? icdbg_pkg::ICDBG_OP_DCFLUSH : icdbg_pkg::ICDBG_OP_STOREBACK, eas[2]);
            `CHK("dc_req_o", 1'b1, dc_req_o)
            `CHK("dc_flush_o", k[0], dc_flush_o)
            `CHK("maint_ea_o", eas[2], maint_ea_o)
            @(negedge clock_i);
            `CHK("cmd_ready_o busy", 1'b0, cmd_ready_o)
            wait_ready();
            `CHK("dc_req_o end", 1'b0, dc_req_o)
        end
        issue(icdbg_pkg::ICDBG_OP_ICINVAL, 32'h0000_1A20);
        `CHK("ic_inval_o", 1'b1, ic_inval_o)
        `CHK("maint_ea_o inval", 32'h0000_1A20, maint_ea_o)
        @(negedge clock_i);
        `CHK("ic_inval_o end", 1'b0, ic_inval_o)
        issue(icdbg_pkg::ICDBG_OP_NONE, 32'h0000_0040);
        `CHK("ic_inval_o none", 1'b0, ic_inval_o)
        `CHK("dc_req_o none", 1'b0, dc_req_o)
        `CHK("prefetch_discard_o none", 1'b0, prefetch_discard_o)
        `CHK("cmd_ready_o none", 1'b1, cmd_ready_o)
        @(negedge clock_i);
        mem_pending_i = 1'b1;
        issue(icdbg_pkg::ICDBG_OP_MEMSYNC, 32'h0000_0000);
        repeat (4) @(negedge clock_i);
        `CHK("cmd_ready_o stall", 1'b0, cmd_ready_o)
        mem_pending_i = 1'b0;
        wait_ready();
        issue(icdbg_pkg::ICDBG_OP_MEMSYNC, 32'h0000_0000);
        `CHK("cmd_ready_o free", 1'b1, cmd_ready_o)
        give_verdict();
    end
endmodule : testbench
